// File: rtl/brw_pkg.sv
// package for the board reset and watchdog block
package brw_pkg;

    // register offsets
    localparam logic [3:0] BRW_OFS_CTRL = 4'h0;
    localparam logic [3:0] BRW_OFS_KICK = 4'h1;
    localparam logic [3:0] BRW_OFS_STAT = 4'h2;
    localparam logic [3:0] BRW_OFS_MASK = 4'h3;
    localparam logic [3:0] BRW_OFS_CAUSE = 4'h4;

    // control field positions
    localparam int BRW_CTRL_EN = 0;
    localparam int BRW_CTRL_MODE_LO = 1;
    localparam int BRW_CTRL_TSEL_LO = 4;
    localparam int BRW_CTRL_RSTEN = 8;

    // status bit positions
    localparam int BRW_ST_WDIRQ = 0;
    localparam int BRW_ST_WDRST = 1;
    localparam int BRW_ST_BUTTON = 2;
    localparam int BRW_ST_PRST = 3;
    localparam int BRW_ST_BPRST = 4;
    localparam int BRW_ST_SUPPLY = 5;

    // reset values
    localparam logic [7:0] BRW_CTRL_RST = 8'h00;
    localparam logic [5:0] BRW_MASK_RST = 6'h00;
    localparam logic [1:0] BRW_CAUSE_RST = 2'h0;

    // timing
    localparam int BRW_CLK_HZ = 40000000;
    localparam int BRW_BASE_MS = 125;
    localparam int BRW_LONG_S = 4096;
    localparam int BRW_STEPS = 16;
    localparam int BRW_TICK_CYC = BRW_CLK_HZ / 1000 * BRW_BASE_MS;
    localparam int BRW_PULSE_US = 100;
    localparam int BRW_PULSE_CYC = BRW_CLK_HZ / 1000000 * BRW_PULSE_US;

    // watchdog action modes
    typedef enum logic [1:0] {
        BRW_ACT_IRQ = 2'b00,
        BRW_ACT_RST = 2'b01,
        BRW_ACT_DUAL = 2'b10
    } brw_act_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } brw_bus_t;

    // watchdog control
    typedef struct packed {
        logic en;
        brw_act_t act;
        logic [3:0] tsel;
    } brw_wdcfg_t;

endpackage : brw_pkg

// File: rtl/brw_sync.sv
// two-flop synchroniser for external pins
`timescale 1ns/1ps
module brw_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pin,
    output logic sync
);
    import brw_pkg::*;

    logic meta; // first stage, read only by second

    // two flops in series
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
        end
    end
endmodule : brw_sync

// File: rtl/brw_stretch.sv
// stretches a one-cycle event into a fixed-length reset pulse
`timescale 1ns/1ps
module brw_stretch (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic trig,
    output logic active
);
    import brw_pkg::*;

    logic [15:0] cnt; // remaining cycles

    // reload on trigger, count down otherwise
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 16'h0000;
        end else if (trig) begin
            cnt <= 16'(BRW_PULSE_CYC);
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end
    end

    assign active = (cnt != 16'h0000);
endmodule : brw_stretch

// File: rtl/brw_top.sv
// board reset collector with two-stage watchdog and register port
//
// Operation
// - sixteen timeouts, 125 ms up to 4096 s
// - unserviced timeout gives interrupt or reset
// - dual mode: interrupt first, then reset
// - flag shows watchdog caused last reset
// - hold reset while 5 V rail low
// - hold reset while 3.3 V rail low
// - hold reset while converter fails
// - push-button resets on press edge
// - watchdog expiry resets on its edge
// - backplane push-button resets on falling edge
// - peripheral-mode backplane reset needs enable
// - any accepted source drives board reset
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module brw_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic mon5_low,
    input wire logic mon33_low,
    input wire logic dcdc_fail,
    input wire logic button_n,
    input wire logic bp_prst_n,
    input wire logic bp_rst_n,
    input wire logic periph_mode,
    output logic board_rst,
    output logic irq,
    output logic wd_active
);
    import brw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic s_mon5; // 5 V low, synced
    logic s_mon33; // 3.3 V low, synced
    logic s_dcdc; // converter fail, synced
    logic s_btn_n; // button, synced
    logic s_prst_n; // backplane push-button, synced
    logic s_bprst_n; // backplane reset, synced
    logic s_periph; // peripheral mode, synced

    brw_sync u_sy0 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(mon5_low), .sync(s_mon5));
    brw_sync u_sy1 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(mon33_low), .sync(s_mon33));
    brw_sync u_sy2 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(dcdc_fail), .sync(s_dcdc));
    brw_sync u_sy3 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(button_n), .sync(s_btn_n));
    brw_sync u_sy4 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(bp_prst_n), .sync(s_prst_n));
    brw_sync u_sy5 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(bp_rst_n), .sync(s_bprst_n));
    brw_sync u_sy6 (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(periph_mode), .sync(s_periph));

    ////////////////////////////////////////////////////////////////////////
    // bus request bundle

    brw_bus_t bus; // register port request
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synced pins

    logic btn_d; // previous button level
    logic prst_d; // previous backplane push-button level
    logic bprst_d; // previous backplane reset level
    logic btn_ev; // button press edge
    logic prst_ev; // backplane push-button edge
    logic bprst_ev; // accepted backplane reset edge
    logic rsten; // software enable for backplane reset

    // history of active-low pins; reset low to match the synchroniser reset
    // level, so the rise of a synced pin after reset is never taken as a press
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            btn_d <= 1'b0;
            prst_d <= 1'b0;
            bprst_d <= 1'b0;
        end else begin
            btn_d <= s_btn_n;
            prst_d <= s_prst_n;
            bprst_d <= s_bprst_n;
        end
    end

    assign btn_ev = btn_d & ~s_btn_n;
    assign prst_ev = prst_d & ~s_prst_n;
    assign bprst_ev = bprst_d & ~s_bprst_n & s_periph & rsten;

    ////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] ctrl; // watchdog control, bits 7:0
    logic [5:0] mask; // interrupt mask
    brw_wdcfg_t cfg; // decoded watchdog control
    logic kick; // watchdog retrigger strobe

    // control and mask written by software
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= BRW_CTRL_RST;
            mask <= BRW_MASK_RST;
        end else if (bus.wr) begin
            if (bus.addr == BRW_OFS_CTRL) begin
                ctrl <= bus.wdata[7:0];
            end
            if (bus.addr == BRW_OFS_MASK) begin
                mask <= bus.wdata[5:0];
            end
        end
    end

    // rsten held in its own flop, bit 8 of control
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsten <= 1'b0;
        end else if (bus.wr && bus.addr == BRW_OFS_CTRL) begin
            rsten <= bus.wdata[BRW_CTRL_RSTEN];
        end
    end

    // one driver for the whole decoded control word
    assign cfg = '{
        en: ctrl[BRW_CTRL_EN],
        act: brw_act_t'(ctrl[BRW_CTRL_MODE_LO +: 2]),
        tsel: ctrl[BRW_CTRL_TSEL_LO +: 4]
    };
    assign kick = bus.wr && (bus.addr == BRW_OFS_KICK);

    ////////////////////////////////////////////////////////////////////////
    // watchdog timebase and counter

    // timeout in 125 ms ticks for each setting
    function automatic logic [15:0] wd_limit(input logic [3:0] sel);
        wd_limit = 16'h0001 << sel;
    endfunction : wd_limit

    logic [22:0] tick_cnt; // cycles within one base tick
    logic tick; // one base tick elapsed
    logic [15:0] wd_cnt; // ticks elapsed since retrigger
    logic expire; // one-cycle timeout event

    // base tick prescaler, 125 ms
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= 23'h000000;
        end else if (!cfg.en || kick || tick) begin
            tick_cnt <= 23'h000000;
        end else begin
            tick_cnt <= tick_cnt + 23'h000001;
        end
    end

    assign tick = (tick_cnt == 23'(BRW_TICK_CYC - 1));

    // watchdog stage machine, gray along idle-armed-warned
    typedef enum logic [1:0] {
        BRW_WD_IDLE = 2'b00,
        BRW_WD_ARMED = 2'b01,
        BRW_WD_WARNED = 2'b11
    } brw_wdst_t;

    brw_wdst_t wd_st; // stage state
    logic wd_irq_ev; // interrupt stage event
    logic wd_rst_ev; // reset stage event
    logic at_limit; // count reached selected timeout

    // a retrigger in the expiry cycle counts as serviced in time
    assign at_limit = tick && !kick && (wd_cnt + 16'h0001 == wd_limit(cfg.tsel));
    assign expire = at_limit;

    // tick count since last retrigger
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wd_cnt <= 16'h0000;
        end else if (!cfg.en || kick || at_limit) begin
            wd_cnt <= 16'h0000;
        end else if (tick) begin
            wd_cnt <= wd_cnt + 16'h0001;
        end
    end

    // stage progression
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wd_st <= BRW_WD_IDLE;
        end else begin
            case (wd_st)
                BRW_WD_IDLE: begin
                    if (cfg.en) begin
                        wd_st <= BRW_WD_ARMED;
                    end
                end
                BRW_WD_ARMED: begin
                    if (!cfg.en) begin
                        wd_st <= BRW_WD_IDLE;
                    end else if (expire && cfg.act == BRW_ACT_DUAL) begin
                        wd_st <= BRW_WD_WARNED;
                    end
                end
                BRW_WD_WARNED: begin
                    if (!cfg.en) begin
                        wd_st <= BRW_WD_IDLE;
                    end else if (kick) begin
                        wd_st <= BRW_WD_ARMED; // serviced in time
                    end else if (expire) begin
                        wd_st <= BRW_WD_ARMED; // reset issued
                    end
                end
                default: begin
                    wd_st <= BRW_WD_IDLE;
                end
            endcase
        end
    end

    // event decode per mode
    always_comb begin
        wd_irq_ev = 1'b0;
        wd_rst_ev = 1'b0;
        if (expire) begin
            case (cfg.act)
                BRW_ACT_IRQ: wd_irq_ev = (wd_st == BRW_WD_ARMED);
                BRW_ACT_RST: wd_rst_ev = (wd_st == BRW_WD_ARMED);
                BRW_ACT_DUAL: begin
                    wd_irq_ev = (wd_st == BRW_WD_ARMED);
                    wd_rst_ev = (wd_st == BRW_WD_WARNED);
                end
                default: wd_rst_ev = (wd_st == BRW_WD_ARMED);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset pulse stretchers

    logic str_wd; // watchdog reset pulse
    logic str_btn; // button reset pulse
    logic str_prst; // backplane push-button pulse
    logic str_bprst; // backplane reset pulse

    brw_stretch u_st0 (.clk_sys(clk_sys), .sys_rst(sys_rst), .trig(wd_rst_ev), .active(str_wd));
    brw_stretch u_st1 (.clk_sys(clk_sys), .sys_rst(sys_rst), .trig(btn_ev), .active(str_btn));
    brw_stretch u_st2 (.clk_sys(clk_sys), .sys_rst(sys_rst), .trig(prst_ev), .active(str_prst));
    brw_stretch u_st3 (.clk_sys(clk_sys), .sys_rst(sys_rst), .trig(bprst_ev), .active(str_bprst));

    ////////////////////////////////////////////////////////////////////////
    // board reset output

    logic supply_bad; // any level source active

    assign supply_bad = s_mon5 | s_mon33 | s_dcdc;

    // registered combination of all sources
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            board_rst <= 1'b1;
        end else begin
            board_rst <= supply_bad | str_wd | str_btn | str_prst | str_bprst;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flag, survives the board reset

    logic [1:0] cause; // bit0 watchdog, bit1 other source

    // latched on each accepted edge source
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cause <= BRW_CAUSE_RST;
        end else if (wd_rst_ev) begin
            cause <= 2'b01;
        end else if (btn_ev | prst_ev | bprst_ev | supply_bad) begin
            cause <= 2'b10;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status

    logic [5:0] stat; // sticky events
    logic [5:0] ev; // events this cycle
    logic stat_rd; // status read clears

    assign ev = {supply_bad, bprst_ev, prst_ev, btn_ev, wd_rst_ev, wd_irq_ev};
    assign stat_rd = bus.rd && (bus.addr == BRW_OFS_STAT);

    // set wins over read clear
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stat <= 6'h00;
        end else begin
            stat <= (stat_rd ? 6'h00 : stat) | ev;
        end
    end

    // level interrupt from flop
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_rd ? 6'h00 : stat) | ev) & mask);
        end
    end

    // watchdog running indicator
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wd_active <= 1'b0;
        end else begin
            wd_active <= cfg.en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after strobe

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr)
                BRW_OFS_CTRL: reg_rdata <= {7'h00, rsten, ctrl};
                BRW_OFS_KICK: reg_rdata <= wd_cnt;
                BRW_OFS_STAT: reg_rdata <= {10'h000, stat};
                BRW_OFS_MASK: reg_rdata <= {10'h000, mask};
                BRW_OFS_CAUSE: reg_rdata <= {14'h0000, cause};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : brw_top

// File: verification/brw_monitor.sv
// concurrent checks on the ports of the board reset block
`timescale 1ns/1ps
module brw_monitor
    import brw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic mon5_low,
    input wire logic mon33_low,
    input wire logic dcdc_fail,
    input wire logic button_n,
    input wire logic bp_prst_n,
    input wire logic bp_rst_n,
    input wire logic periph_mode,
    input wire logic board_rst,
    input wire logic irq,
    input wire logic wd_active
);
    // one clock domain
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // level sources hold reset
    AST_RAIL5: assert property (mon5_low [*4] |-> board_rst)
        else $error("5 V rail low but no reset");
    AST_RAIL33: assert property (mon33_low [*4] |-> board_rst)
        else $error("3.3 V rail low but no reset");
    AST_DCDC: assert property (dcdc_fail [*4] |-> board_rst)
        else $error("converter fail but no reset");
    // edge sources start reset; backplane reset gives none outside peripheral mode
    AST_BUTTON: assert property ($fell(button_n) |-> ##[2:5] board_rst)
        else $error("button press gave no reset");
    AST_PRST: assert property ($fell(bp_prst_n) |-> ##[2:5] board_rst)
        else $error("backplane button gave no reset");
    AST_BPRST_OFF: assert property (($fell(bp_rst_n) && !periph_mode && button_n
        && bp_prst_n && !mon5_low && !mon33_low && !dcdc_fail && !board_rst)
        |-> ##1 !board_rst [*5])
        else $error("backplane reset taken outside peripheral mode");
    // edge pulse has a minimum length
    AST_STRETCH: assert property (($rose(board_rst) && !mon5_low && !mon33_low
        && !dcdc_fail) |-> board_rst [*8])
        else $error("reset pulse too short");
    // register port
    AST_IRQ_CLR: assert property ((reg_rd && reg_addr == BRW_OFS_STAT) ##1
        (reg_rdata == 16'h0000) |-> !irq)
        else $error("irq high with empty status");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_WD_EN: assert property ((reg_wr && reg_addr == BRW_OFS_CTRL)
        |-> ##2 (wd_active == $past(reg_wdata[0], 2)))
        else $error("watchdog enable not followed");
endmodule : brw_monitor

bind brw_top brw_monitor u_brw_monitor (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .mon5_low, .mon33_low, .dcdc_fail, .button_n,
    .bp_prst_n, .bp_rst_n, .periph_mode, .board_rst, .irq, .wd_active);

// File: verification/brw_board_model.sv
// supervisors and backplane driving the reset pins
`timescale 1ns/1ps
module brw_board_model (
    input wire logic clk_sys,
    input wire logic [5:0] req,
    output logic mon5_low = 1'b0,
    output logic mon33_low = 1'b0,
    output logic dcdc_fail = 1'b0,
    output logic button_n = 1'b1,
    output logic bp_prst_n = 1'b1,
    output logic bp_rst_n = 1'b1
);
    // pins move just after the edge
    always @(posedge clk_sys) begin
        mon5_low <= req[0];
        mon33_low <= req[1];
        dcdc_fail <= req[2];
        button_n <= ~req[3];
        bp_prst_n <= ~req[4];
        bp_rst_n <= ~req[5];
    end
endmodule : brw_board_model

// File: verification/brw_top_bench.sv
// self-checking bench for the board reset and watchdog block
`timescale 1ns/1ps
module brw_top_bench;
    import brw_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic periph_mode = 1'b0;
    logic [5:0] req = 6'h00; // partner pin requests
    logic [15:0] reg_rdata;
    logic mon5_low, mon33_low, dcdc_fail, button_n, bp_prst_n, bp_rst_n;
    logic board_rst, irq, wd_active;
    int errors = 0;
    int total_checks = 0;
    ////////////////////////////////////////////////////////////////
    brw_top u_brw_top (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .mon5_low, .mon33_low, .dcdc_fail, .button_n, .bp_prst_n,
        .bp_rst_n, .periph_mode, .board_rst, .irq, .wd_active);
    brw_board_model u_brw_board_model (.clk_sys, .req, .mon5_low, .mon33_low,
        .dcdc_fail, .button_n, .bp_prst_n, .bp_rst_n);
    // 40 MHz clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t pin %h exp %h", $time, got, exp);
        end
    endtask : chk1
    // one-cycle write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // read, data sampled in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk16(reg_rdata, exp);
    endtask : rd_chk
    // clear status and expect irq gone a cycle later
    task automatic stat_chk(input logic [15:0] st, input logic ir);
        chk1(irq, ir);
        rd_chk(BRW_OFS_STAT, st);
        @(posedge clk_sys);
        #1 chk1(irq, 1'b0);
    endtask : stat_chk
    // held level source, then release
    task automatic lvl(input int i, input logic ir);
        req[i] <= 1'b1;
        repeat (50) @(posedge clk_sys);
        #1 chk1(board_rst, 1'b1);
        req[i] <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 chk1(board_rst, 1'b0);
        stat_chk(16'h0020, ir);
    endtask : lvl
    // short press of an edge source, pulse length counted
    task automatic press(input int i, input logic fire, input logic [15:0] st,
                         input logic ir);
        int len;
        len = 0;
        @(posedge clk_sys);
        req[i] <= 1'b1;
        for (int n = 0; n < 4200; n++) begin
            @(posedge clk_sys);
            if (n == 10) req[i] <= 1'b0;
            #1;
            if (board_rst === 1'b1) len++;
        end
        chk1(fire ? (len >= BRW_PULSE_CYC && len <= BRW_PULSE_CYC + 2) : (len == 0),
             1'b1);
        stat_chk(st, ir);
    endtask : press
    ////////////////////////////////////////////////////////////////
    // run limit
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(BRW_OFS_CTRL, 16'h0000);
        rd_chk(BRW_OFS_STAT, 16'h0000);
        rd_chk(BRW_OFS_MASK, 16'h0000);
        rd_chk(BRW_OFS_CAUSE, 16'h0000);
        chk1(board_rst, 1'b0);
        chk1(wd_active, 1'b0);
        // dual mode, longest timeout, backplane enable
        wr(BRW_OFS_CTRL, 16'h01f5);
        rd_chk(BRW_OFS_CTRL, 16'h01f5);
        chk1(wd_active, 1'b1);
        wr(BRW_OFS_KICK, 16'h0000);
        rd_chk(BRW_OFS_KICK, 16'h0000);
        wr(4'hf, 16'hffff);
        rd_chk(4'hf, 16'h0000);
        wr(BRW_OFS_CTRL, 16'h0100);
        rd_chk(BRW_OFS_CTRL, 16'h0100);
        chk1(wd_active, 1'b0);
        // masked button press
        press(3, 1'b1, 16'h0004, 1'b0);
        rd_chk(BRW_OFS_CAUSE, 16'h0002);
        wr(BRW_OFS_MASK, 16'h003f);
        rd_chk(BRW_OFS_MASK, 16'h003f);
        press(4, 1'b1, 16'h0008, 1'b1);
        lvl(0, 1'b1);
        lvl(1, 1'b1);
        lvl(2, 1'b1);
        // backplane reset gating
        press(5, 1'b0, 16'h0000, 1'b0);
        periph_mode <= 1'b1;
        wr(BRW_OFS_CTRL, 16'h0000);
        press(5, 1'b0, 16'h0000, 1'b0);
        wr(BRW_OFS_CTRL, 16'h0100);
        press(5, 1'b1, 16'h0010, 1'b1);
        give_verdict();
    end
endmodule : brw_top_bench
